// ==== bench/pls_host_model.sv ====
// Host controller model: SPI master in mode 0, most significant bit first.
`default_nettype none
module pls_host_model (
   input wire logic clk_i, // Pacing clock
   output logic cs_n_o,    // Chip select, active low
   output logic sclk_o,    // Serial clock, idle low
   output logic mosi_o,    // Data to the device
   input wire logic miso_i // Data from the device
);
   timeunit 1ns;
   timeprecision 1ps;
   // Interface selection is strapped outside this port; SPI is assumed.
   // Half of the 400 ns link period, in 50 ns clock cycles.
   localparam int HALF = 4;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Every command starts with a fresh chip select fall.
   task automatic select();
      tick(HALF);
      cs_n_o = 1'b0;
      tick(HALF);
   endtask
   // A released data line shows the inverse of its last bit, so nothing leans on a held value.
   task automatic deselect();
      tick(HALF);
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      tick(2 * HALF);
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi_o = tx[i];
         tick(HALF);
         sclk_o = 1'b1;
         rx[i] = miso_i;
         tick(HALF);
         sclk_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ==== bench/tb_powerline_spi_host_port.sv ====
// Self-checking bench for the powerline SPI host port.
`default_nettype none
module tb_powerline_spi_host_port
   import pls_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0] c;
      logic [7:0] a;
      logic [7:0] b;
      int n;
      logic chk;
      logic [7:0] exp;
   } pls_row_t;
   pls_row_t rows[13] = '{
      '{8'hFD, 8'h00, 8'hFF, 3, 1'b1, 8'h41}, '{8'hFD, 8'h04, 8'hFF, 3, 1'b1, 8'hBF},
      '{8'hFD, 8'h08, 8'hFF, 3, 1'b1, 8'h00}, '{8'hF5, 8'h04, 8'h55, 3, 1'b0, 8'h00},
      '{8'hFD, 8'h04, 8'hFF, 3, 1'b1, 8'h55}, '{8'hF5, 8'h08, 8'h12, 3, 1'b0, 8'h00},
      '{8'hFD, 8'h08, 8'hFF, 3, 1'b1, 8'h00}, '{8'hF5, 8'h04, 8'hFF, 3, 1'b0, 8'h00},
      '{8'hFD, 8'h04, 8'hFF, 3, 1'b1, 8'hFF}, '{8'hF5, 8'h00, 8'h42, 3, 1'b0, 8'h00},
      '{8'hFD, 8'h00, 8'hFF, 3, 1'b1, 8'h42}, '{8'h01, 8'hFF, 8'hFF, 2, 1'b1, 8'h10},
      '{8'h11, 8'hFF, 8'hFF, 2, 1'b1, 8'h00}};
   logic [7:0] opens[4] = '{CMD_TX_OPEN_0, CMD_TX_OPEN_1, CMD_TX_OPEN_2, CMD_TX_OPEN_3};
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic cs_n, sclk, mosi, miso, irq, pop, open, push, close;
   logic [1:0] codec;
   logic [7:0] txd, carrier, irqen, rb, seen_data, n_close = 8'h00;
   logic [1:0] seen_codec;
   logic [4:0] ev = 5'h00;
   logic rx_empty = 1'b1;
   logic rx_last = 1'b0;
   logic [1:0] tx_st = 2'b00;
   logic [7:0] rx_data = 8'h00;
   int errors = 0;
   int n_checks = 0;
   always #25 clk_i = ~clk_i;
   pls_host_model u_host (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi),
      .miso_i(miso));
   pls_spi_port u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .host_chip_select_n_i(cs_n),
      .host_sclk_i(sclk), .host_serial_in_i(mosi), .host_serial_out_o(miso),
      .host_irq_o(irq), .rx_frame_done_i(ev[2]), .rx_thresh_i(ev[3]),
      .rx_empty_i(rx_empty), .rx_last_byte_i(rx_last), .rx_data_i(rx_data), .rx_pop_o(pop),
      .null_frame_i(ev[4]), .tx_status_i(tx_st), .rx_ovf_i(ev[0]), .tx_ovf_i(ev[1]),
      .tx_open_o(open), .tx_codec_o(codec), .tx_push_o(push), .tx_data_o(txd),
      .tx_close_o(close), .carrier_o(carrier), .irq_enable_o(irqen));
   // ---------------------------------------------------------------
   // Far-side bookkeeping: a one-byte receive queue and transmit capture
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (pop) rx_empty <= 1'b1;
      if (open) seen_codec <= codec;
      if (push) seen_data <= txd;
      if (close) n_close <= n_close + 8'h01;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic pulse(input int i);
      ev[i] = 1'b1;
      tick(1);
      ev[i] = 1'b0;
      tick(6);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b, int n);
      u_host.select();
      u_host.xfer(c, rb);
      if (n > 1) u_host.xfer(a, rb);
      if (n > 2) u_host.xfer(b, rb);
      u_host.deselect();
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      if (errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #1_000_000;
      errors++;
      wrap_up();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      tick(3);
      rstn_i = 1'b1;
      tick(4);
      chk(carrier, 8'h41);
      chk({miso, irq, open, push, close, 3'h0}, 8'h80);
      foreach (rows[i]) begin
         cmd(rows[i].c, rows[i].a, rows[i].b, rows[i].n);
         if (rows[i].chk) chk(rb, rows[i].exp);
      end
      chk(irqen, 8'hFF);
      chk(carrier, 8'h42);
      // Errors stay flagged through a status read and clear only on the error read.
      pulse(0);
      pulse(1);
      cmd(8'h77, 8'h00, 8'h00, 1);
      cmd(CMD_STATUS_READ, FILL_BYTE, 8'h00, 2);
      chk(rb, 8'h90);
      chk({7'h00, irq}, 8'h01);
      cmd(CMD_ERROR_READ, FILL_BYTE, 8'h00, 2);
      chk(rb, 8'h0E);
      tick(6);
      chk({7'h00, irq}, 8'h00);
      for (int k = 0; k < 4; k++) begin
         u_host.select();
         u_host.xfer(opens[k], rb);
         u_host.xfer(8'h55 + 8'(k), rb);
         chk(rb, 8'h10);
         u_host.deselect();
         chk({6'h00, seen_codec}, 8'(k));
         chk(seen_data, 8'h55 + 8'(k));
         cmd(CMD_FRAME_CLOSE, 8'h00, 8'h00, 1);
         chk(n_close, 8'(k + 1));
      end
      rx_data = 8'hA5;
      rx_last = 1'b1;
      rx_empty = 1'b0;
      pulse(2);
      chk({7'h00, irq}, 8'h01);
      cmd(CMD_STATUS_READ, FILL_BYTE, 8'h00, 2);
      chk(rb, 8'h04);
      tick(6);
      chk({7'h00, irq}, 8'h00);
      cmd(CMD_RX_FETCH, FILL_BYTE, 8'h00, 2);
      chk(rb, 8'hA5);
      chk({7'h00, irq}, 8'h01);
      // The host stops at the end-of-frame interrupt and reads status afresh.
      cmd(CMD_STATUS_READ, FILL_BYTE, 8'h00, 2);
      chk(rb, 8'h30);
      rx_last = 1'b0;
      rx_empty = 1'b0;
      pulse(3);
      cmd(CMD_STATUS_READ, FILL_BYTE, 8'h00, 2);
      chk(rb, 8'h08);
      u_host.select();
      u_host.xfer(CMD_RX_FETCH, rb);
      pulse(2);
      chk({7'h00, irq}, 8'h01);
      u_host.xfer(FILL_BYTE, rb);
      u_host.deselect();
      cmd(CMD_STATUS_READ, FILL_BYTE, 8'h00, 2);
      chk(rb, 8'h14);
      pulse(4);
      chk({7'h00, irq}, 8'h01);
      cmd(CMD_STATUS_READ, FILL_BYTE, 8'h00, 2);
      chk(rb, 8'h50);
      // Transmit level bits show in the status byte but never raise the interrupt.
      tx_st = 2'b11;
      cmd(CMD_STATUS_READ, FILL_BYTE, 8'h00, 2);
      chk(rb, 8'h13);
      chk({7'h00, irq}, 8'h00);
      // A reset in mid-run must bring back the default configuration.
      rstn_i = 1'b0;
      tick(2);
      rstn_i = 1'b1;
      tick(4);
      chk(carrier, 8'h41);
      chk(irqen, 8'hBF);
      cmd(CMD_REG_READ, REG_CARRIER, FILL_BYTE, 3);
      chk(rb, 8'h41);
      wrap_up();
   end
endmodule
`default_nettype wire

// ==== src/pls_pkg.sv ====
// Package of constants for the powerline SPI host port.
`default_nettype none
package pls_pkg;
   // ---------------------------------------------------------------
   // Command opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_TX_OPEN_0 = 8'h04;
   localparam logic [7:0] CMD_TX_OPEN_1 = 8'h14;
   localparam logic [7:0] CMD_TX_OPEN_2 = 8'h24;
   localparam logic [7:0] CMD_TX_OPEN_3 = 8'h34;
   localparam logic [7:0] CMD_FRAME_CLOSE = 8'h0F;
   localparam logic [7:0] CMD_RX_FETCH = 8'h0B;
   localparam logic [7:0] CMD_REG_WRITE = 8'hF5;
   localparam logic [7:0] CMD_REG_READ = 8'hFD;
   localparam logic [7:0] CMD_STATUS_READ = 8'h01;
   localparam logic [7:0] CMD_ERROR_READ = 8'h11;
   // ---------------------------------------------------------------
   // Status and error bit positions
   // ---------------------------------------------------------------
   localparam int ST_RX_FRAME_END = 2;
   localparam int ST_RX_NOT_EMPTY = 3;
   localparam int ST_RX_EMPTY = 4;
   localparam int ST_EOF = 5;
   localparam int ST_NULL_FRAME = 6;
   localparam int ST_ERROR = 7;
   localparam int ER_RX_OVF = 1;
   localparam int ER_TX_OVF = 2;
   localparam int ER_ILLEGAL = 3;
   // ---------------------------------------------------------------
   // Configuration register map and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CARRIER = 8'h00;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h04;
   localparam logic [7:0] CARRIER_RESET = 8'h41;
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'hBF;
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   // ---------------------------------------------------------------
   // Command state
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PLS_IDLE = 3'b000,
      PLS_CMD = 3'b001,
      PLS_ADDR = 3'b010,
      PLS_DATA = 3'b011,
      PLS_STREAM = 3'b100,
      PLS_DEAD = 3'b101
   } pls_state_t;
endpackage
`default_nettype wire

// ==== src/pls_spi_port.sv ====
// SPI slave host port: command decode, registers, status and error bytes.
//
// Overview of operation
// - Error byte: bit1 rx overflow, bit2 tx overflow, bit3 illegal command.
// - Opcode 0x11 then eight clocks shift out the error byte.
// - Chip select rising after error read clears error-caused interrupt.
// - Carrier setting resets to its 13 MHz default code.
// - 0xF5, address, data; data stored when chip select rises.
// - 0xFD, address, dummy; addressed register value shifted out.
// - Frame opened by open opcode, closed by separate 0x0F transaction.
// - During transmit payload bytes the status byte is shifted out.
// - Frame-end sets status bit 2 and interrupt; status read drops it.
// - Last byte fetched by 0x0B raises EOF and interrupt again.
// - Threshold reached sets status bit 3 even with frame incomplete.
// - Frame completion during a fetch raises interrupt mid-fetch.
// - Empty frame, if enabled, sets bit 6 and interrupt.
// - Frame-end set only by an rx_frame_done_i pulse; an EOF does not re-raise it.
// - Port pins: data in, data out, serial clock, interrupt, chip select.
// - First byte after select fall is command; extras ignored.
// - Open opcodes 0x04/14/24/34 select codec 0 to 3.
`default_nettype none
module pls_spi_port
   import pls_pkg::*;
(
   input wire logic clk_i,              // System clock, 20 MHz
   input wire logic rstn_i,             // Asynchronous reset, active low
   input wire logic host_chip_select_n_i, // Chip select from host, active low
   input wire logic host_sclk_i,        // Serial clock from host
   input wire logic host_serial_in_i,   // Serial data from host
   output logic host_serial_out_o,      // Serial data to host
   output logic host_irq_o,             // Interrupt to host, active high
   input wire logic rx_frame_done_i,    // Pulse: complete frame entered rx FIFO
   input wire logic rx_thresh_i,        // Pulse: rx count reached threshold
   input wire logic rx_empty_i,         // Level: rx FIFO empty
   input wire logic rx_last_byte_i,     // Level: head byte ends its frame
   input wire logic [7:0] rx_data_i,    // Head byte of rx FIFO
   output logic rx_pop_o,               // Pulse: one rx byte taken
   input wire logic null_frame_i,       // Pulse: empty frame received
   input wire logic [1:0] tx_status_i,  // Tx almost-empty/almost-full bits
   input wire logic rx_ovf_i,           // Pulse: rx FIFO overflow
   input wire logic tx_ovf_i,           // Pulse: tx FIFO overflow
   output logic tx_open_o,              // Pulse: frame opened
   output logic [1:0] tx_codec_o,       // Codec of opened frame
   output logic tx_push_o,              // Pulse: payload byte valid
   output logic [7:0] tx_data_o,        // Payload byte
   output logic tx_close_o,             // Pulse: frame closed
   output logic [7:0] carrier_o,        // Carrier setting
   output logic [7:0] irq_enable_o      // Interrupt enable mask
);
   // ---------------------------------------------------------------
   // Input synchronisers and edge detection
   // ---------------------------------------------------------------
   logic [1:0] cs_sync, sck_sync, din_sync;
   logic cs_d, sck_d;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cs_sync <= 2'b11;
         sck_sync <= 2'b00;
         din_sync <= 2'b00;
         cs_d <= 1'b1;
         sck_d <= 1'b0;
      end else begin
         cs_sync <= {cs_sync[0], host_chip_select_n_i};
         sck_sync <= {sck_sync[0], host_sclk_i};
         din_sync <= {din_sync[0], host_serial_in_i};
         cs_d <= cs_sync[1];
         sck_d <= sck_sync[1];
      end
   end
   wire cs_n = cs_sync[1];
   wire cs_rise = cs_n & ~cs_d;
   wire sck_rise = ~cs_n & sck_sync[1] & ~sck_d;
   wire sck_fall = ~cs_n & ~sck_sync[1] & sck_d;

   // ---------------------------------------------------------------
   // Command engine
   // ---------------------------------------------------------------
   pls_state_t state, next_state;
   logic [7:0] cmd, next_cmd, addr, next_addr, wdata, next_wdata;
   logic [7:0] shin, next_shin, shout, next_shout;
   logic [2:0] bitcnt, next_bitcnt;
   logic wpend, next_wpend, errpend, next_errpend;
   logic [7:0] carrier, next_carrier, irq_en, next_irq_en;
   logic [7:0] status, next_status, err, next_err;
   logic [7:0] status_view;
   logic byte_done, load, pop, push, open_p, close_p, st_clr;
   logic [7:0] rx_byte;
   logic next_dout, dout;

   assign rx_byte = {shin[6:0], din_sync[1]};
   assign byte_done = sck_rise && bitcnt == 3'd7;
   // Rx-empty and tx status bits are live, the rest are sticky events.
   assign status_view = {err != 8'h00 ? 1'b1 : 1'b0, status[6:5], rx_empty_i,
      status[3:2], tx_status_i};

   function automatic logic is_open(input logic [7:0] c);
      is_open = c == CMD_TX_OPEN_0 || c == CMD_TX_OPEN_1 ||
         c == CMD_TX_OPEN_2 || c == CMD_TX_OPEN_3;
   endfunction

   always_comb begin
      next_state = state;
      next_cmd = cmd;
      next_addr = addr;
      next_wdata = wdata;
      next_shin = shin;
      next_shout = shout;
      next_bitcnt = bitcnt;
      next_wpend = wpend;
      next_errpend = errpend;
      next_carrier = carrier;
      next_irq_en = irq_en;
      next_dout = dout;
      load = 1'b0;
      pop = 1'b0;
      push = 1'b0;
      open_p = 1'b0;
      close_p = 1'b0;
      st_clr = 1'b0;
      if (sck_rise) begin
         next_shin = rx_byte;
         next_bitcnt = bitcnt + 3'd1;
      end
      if (sck_fall) begin
         next_dout = shout[7];
         next_shout = {shout[6:0], 1'b1};
      end
      case (state)
         PLS_IDLE: begin
            if (!cs_n) begin
               next_state = PLS_CMD;
               next_bitcnt = 3'd0;
               next_shout = FILL_BYTE;
            end
         end
         PLS_CMD: begin
            if (byte_done) begin
               next_cmd = rx_byte;
               load = 1'b1;
               next_state = PLS_DEAD;
               if (is_open(rx_byte)) begin
                  open_p = 1'b1;
                  next_shout = status_view;
                  next_state = PLS_STREAM;
               end else if (rx_byte == CMD_FRAME_CLOSE) begin
                  close_p = 1'b1;
               end else if (rx_byte == CMD_RX_FETCH) begin
                  next_shout = rx_empty_i ? FILL_BYTE : rx_data_i;
                  pop = ~rx_empty_i;
                  next_state = PLS_STREAM;
               end else if (rx_byte == CMD_REG_WRITE || rx_byte == CMD_REG_READ) begin
                  next_state = PLS_ADDR;
               end else if (rx_byte == CMD_STATUS_READ) begin
                  next_shout = status_view;
                  st_clr = 1'b1;
               end else if (rx_byte == CMD_ERROR_READ) begin
                  next_shout = err;
                  next_errpend = 1'b1;
               end
            end
         end
         PLS_ADDR: begin
            if (byte_done) begin
               next_addr = rx_byte;
               if (cmd == CMD_REG_READ) begin
                  next_shout = rx_byte == REG_CARRIER ? carrier :
                     rx_byte == REG_IRQ_ENABLE ? irq_en : 8'h00;
                  next_state = PLS_DEAD;
               end else begin
                  next_state = PLS_DATA;
               end
            end
         end
         PLS_DATA: begin
            if (byte_done) begin
               next_wdata = rx_byte;
               next_wpend = 1'b1;
               next_state = PLS_DEAD;
            end
         end
         PLS_STREAM: begin
            if (byte_done) begin
               if (cmd == CMD_RX_FETCH) begin
                  next_shout = rx_empty_i ? FILL_BYTE : rx_data_i;
                  pop = ~rx_empty_i;
               end else begin
                  push = 1'b1;
                  next_shout = status_view;
               end
            end
         end
         default: ;
      endcase
      if (cs_rise) begin
         next_state = PLS_IDLE;
         next_wpend = 1'b0;
         next_errpend = 1'b0;
         if (wpend && addr == REG_CARRIER) next_carrier = wdata;
         if (wpend && addr == REG_IRQ_ENABLE) next_irq_en = wdata;
      end
   end

   // ---------------------------------------------------------------
   // Sticky status and error bytes; a new event beats a clear.
   // ---------------------------------------------------------------
   logic eof_ev;
   assign eof_ev = pop && rx_last_byte_i;
   always_comb begin
      next_status = st_clr ? 8'h00 : status;
      next_status[ST_RX_FRAME_END] = next_status[ST_RX_FRAME_END] | rx_frame_done_i;
      next_status[ST_RX_NOT_EMPTY] = next_status[ST_RX_NOT_EMPTY] | rx_thresh_i;
      next_status[ST_EOF] = next_status[ST_EOF] | eof_ev;
      next_status[ST_NULL_FRAME] = next_status[ST_NULL_FRAME] |
         (null_frame_i & irq_en[ST_NULL_FRAME]);
      next_err = (cs_rise && errpend) ? 8'h00 : err;
      next_err[ER_RX_OVF] = next_err[ER_RX_OVF] | rx_ovf_i;
      next_err[ER_TX_OVF] = next_err[ER_TX_OVF] | tx_ovf_i;
      next_err[ER_ILLEGAL] = next_err[ER_ILLEGAL] | (load && !is_open(rx_byte) &&
         rx_byte != CMD_FRAME_CLOSE && rx_byte != CMD_RX_FETCH &&
         rx_byte != CMD_REG_WRITE && rx_byte != CMD_REG_READ &&
         rx_byte != CMD_STATUS_READ && rx_byte != CMD_ERROR_READ);
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= PLS_IDLE;
         cmd <= 8'h00;
         addr <= 8'h00;
         wdata <= 8'h00;
         shin <= 8'h00;
         shout <= FILL_BYTE;
         bitcnt <= 3'd0;
         wpend <= 1'b0;
         errpend <= 1'b0;
         carrier <= CARRIER_RESET;
         irq_en <= IRQ_ENABLE_RESET;
         status <= 8'h00;
         err <= 8'h00;
         dout <= 1'b1;
         tx_open_o <= 1'b0;
         tx_codec_o <= 2'b00;
         tx_push_o <= 1'b0;
         tx_data_o <= 8'h00;
         tx_close_o <= 1'b0;
         rx_pop_o <= 1'b0;
      end else begin
         state <= next_state;
         cmd <= next_cmd;
         addr <= next_addr;
         wdata <= next_wdata;
         shin <= next_shin;
         shout <= next_shout;
         bitcnt <= next_bitcnt;
         wpend <= next_wpend;
         errpend <= next_errpend;
         carrier <= next_carrier;
         irq_en <= next_irq_en;
         status <= next_status;
         err <= next_err;
         dout <= next_dout;
         tx_open_o <= open_p;
         if (open_p) tx_codec_o <= rx_byte[5:4];
         tx_push_o <= push;
         if (push) tx_data_o <= rx_byte;
         tx_close_o <= close_p;
         rx_pop_o <= pop;
      end
   end

   assign host_serial_out_o = dout;
   assign host_irq_o = |(status_view & irq_en & 8'hE4) | (err != 8'h00);
   assign carrier_o = carrier;
   assign irq_enable_o = irq_en;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_STATUS_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
      st_clr && !rx_frame_done_i |=> !status[ST_RX_FRAME_END])
      else $error("status not cleared by read");
   AST_FRAME_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rx_frame_done_i |=> status[ST_RX_FRAME_END] &&
      (host_irq_o || !irq_en[ST_RX_FRAME_END]))
      else $error("frame end not latched");
   AST_EOF: assert property (@(posedge clk_i) disable iff (!rstn_i)
      pop && rx_last_byte_i |=> status[ST_EOF])
      else $error("eof not latched");
   AST_ERR_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cs_rise && errpend && !rx_ovf_i && !tx_ovf_i |=> err == 8'h00)
      else $error("error byte not cleared");
   AST_CMD_ONLY_FIRST: assert property (@(posedge clk_i) disable iff (!rstn_i)
      state == PLS_DEAD && byte_done |=> !tx_open_o && !tx_close_o && !rx_pop_o &&
      err[ER_ILLEGAL] == $past(err[ER_ILLEGAL]))
      else $error("command taken after first byte");
   AST_CODEC: assert property (@(posedge clk_i) disable iff (!rstn_i)
      open_p |=> tx_open_o && tx_codec_o == $past(rx_byte[5:4]))
      else $error("codec mismatch");
   AST_WRITE: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cs_rise && wpend && addr == REG_CARRIER |=> carrier == $past(wdata))
      else $error("register write lost");
   AST_IDLE_ON_CS: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cs_rise |=> state == PLS_IDLE ##1 !(tx_push_o || rx_pop_o))
      else $error("not idle after chip select rise");
   AST_NULL: assert property (@(posedge clk_i) disable iff (!rstn_i)
      null_frame_i && irq_en[ST_NULL_FRAME] |=> status[ST_NULL_FRAME] && host_irq_o)
      else $error("null frame not flagged");
   AST_THRESH: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rx_thresh_i |=> status[ST_RX_NOT_EMPTY])
      else $error("threshold not flagged");
endmodule
`default_nettype wire
